// >>> dv/host_model.sv
// host side of the management link: one-byte command writes and reads
// assumes reads are answered one clock after the command edge
`timescale 1ns/1ps

module host_model
    import overcurrent_fault_response_pkg::*;
(
    input  wire logic       clk,
    output cmd_t            cmd,
    input  wire logic [7:0] rdata_q,
    input  wire logic       rvalid_q,
    input  wire logic       rhit_q
);
    initial cmd = '0;

    // ========================================
    // bus cycles
    task automatic wr(input logic [7:0] c, input logic [7:0] v);
        @(posedge clk);
        #1 cmd = '{wr: 1'b1, rd: 1'b0, code: c, wdata: v};
        @(posedge clk);
        #1 cmd = '0;
    endtask

    task automatic rd(input logic [7:0] c, output logic [7:0] v, output logic h);
        @(posedge clk);
        #1 cmd = '{wr: 1'b0, rd: 1'b1, code: c, wdata: 8'h00};
        @(posedge clk);
        #1 cmd = '0;
        // no answer reads as a value no row expects
        v = (rvalid_q === 1'b1) ? rdata_q : 8'hee;
        h = rvalid_q & rhit_q;
    endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the over-current fault response block
// assumes host_model drives the command port; bench drives the pins
`timescale 1ns/1ps

module tb_top
    import overcurrent_fault_response_pkg::*;
;
    logic       clk, rst_n, oc_pin, uv_pin, unit_tick;
    logic       power_on, other_fault, restart_done, fault_clear;
    logic [7:0] rdata_q, d;
    logic       rvalid_q, rhit_q, h, host_notify_q;
    logic       output_enable_q, current_limit_q, fault_status_q, latched_off_q;
    cmd_t       cmd;
    int         mismatches = 0;
    int         checked = 0;
    int         notes = 0;
    // enable, limit, status, latched
    wire  [7:0] st = {4'h0, output_enable_q, current_limit_q, fault_status_q, latched_off_q};

    typedef struct packed {
        logic [7:0] wc;
        logic [7:0] wd;
        logic [7:0] rc;
        logic [7:0] ed;
        logic       eh;
    } row_t;
    row_t rows [5] = '{
        {8'h47, 8'hc5, 8'h47, 8'hc5, 1'b1},
        {8'h47, 8'h3a, 8'h47, 8'h3a, 1'b1},
        {8'h46, 8'hff, 8'h47, 8'h3a, 1'b1},
        {8'h48, 8'h11, 8'h48, 8'h00, 1'b0},
        {8'h47, 8'hc0, 8'h47, 8'hc0, 1'b1}
    };

    overcurrent_fault_response dut (
        .clk(clk), .rst_n(rst_n), .cmd(cmd), .oc_pin(oc_pin), .uv_pin(uv_pin),
        .unit_tick(unit_tick), .power_on(power_on), .other_fault(other_fault),
        .restart_done(restart_done), .fault_clear(fault_clear),
        .rdata_q(rdata_q), .rvalid_q(rvalid_q), .rhit_q(rhit_q),
        .output_enable_q(output_enable_q), .current_limit_q(current_limit_q),
        .fault_status_q(fault_status_q), .host_notify_q(host_notify_q),
        .latched_off_q(latched_off_q)
    );

    host_model host (
        .clk(clk), .cmd(cmd), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .rhit_q(rhit_q)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (host_notify_q === 1'b1) notes <= notes + 1;
    end

    // ========================================
    // helpers
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 unit_tick = 1'b1;
            @(posedge clk);
            #1 unit_tick = 1'b0;
        end
    endtask

    task automatic pins(input logic o, input logic u);
        oc_pin = o;
        uv_pin = u;
        wt(8);
    endtask

    task automatic clr();
        @(posedge clk);
        #1 fault_clear = 1'b1;
        @(posedge clk);
        #1 fault_clear = 1'b0;
        wt(4);
    endtask

    task automatic give_verdict();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    // ========================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        {oc_pin, uv_pin, unit_tick, other_fault, restart_done, fault_clear} = '0;
        power_on = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(st, 8'h00);
        rst_n = 1'b1;
        wt(2);
        chk(st, 8'h08);
        host.rd(8'h47, d, h);
        chk(d, OC_RESP_CFG_RESET);
        foreach (rows[i]) begin
            host.wr(rows[i].wc, rows[i].wd);
            host.rd(rows[i].rc, d, h);
            chk(d, rows[i].ed);
            chk({7'h0, h}, {7'h0, rows[i].eh});
        end
        // immediate shutdown, no retry
        pins(1, 0);
        chk(st, 8'h03);
        chk(notes[7:0], 8'h01);
        pins(0, 0);
        chk(st, 8'h03);
        clr();
        chk(st, 8'h08);
        // one attempt that fails
        host.wr(8'h47, 8'hc8);
        pins(1, 0);
        chk(st, 8'h02);
        ticks(1);
        chk(st, 8'h0a);
        wt(4);
        ticks(1);
        wt(2);
        chk(st, 8'h03);
        pins(0, 0);
        clr();
        // restart succeeds, next fault gets its attempt again
        pins(1, 0);
        pins(0, 0);
        ticks(1);
        @(posedge clk);
        #1 restart_done = 1'b1;
        @(posedge clk);
        #1 restart_done = 1'b0;
        pins(1, 0);
        chk(st, 8'h02);
        pins(0, 0);
        ticks(1);
        chk(st, 8'h0a);
        @(posedge clk);
        #1 restart_done = 1'b1;
        @(posedge clk);
        #1 restart_done = 1'b0;
        chk(st, 8'h0a);
        clr();
        chk(st, 8'h08);
        // brickwall limiting ignores voltage
        host.wr(8'h47, 8'h00);
        pins(1, 1);
        chk(st, 8'h0e);
        pins(0, 0);
        clr();
        // conditioned limiting, cut off on low voltage
        host.wr(8'h47, 8'h40);
        pins(1, 0);
        chk(st, 8'h0e);
        pins(1, 1);
        chk(st, 8'h03);
        pins(0, 0);
        clr();
        // delayed shutdown after two units
        host.wr(8'h47, 8'h81);
        pins(1, 0);
        ticks(1);
        wt(2);
        chk(st, 8'h0e);
        ticks(1);
        wt(2);
        chk(st, 8'h03);
        pins(0, 0);
        clr();
        chk(st, 8'h08);
        // unlimited retry, two units apart, until commanded off
        host.wr(8'h47, 8'hf9);
        pins(1, 0);
        chk(st, 8'h02);
        repeat (7) begin
            ticks(1);
            chk(st, 8'h02);
            ticks(1);
            chk(st, 8'h0a);
        end
        power_on = 1'b0;
        wt(2);
        chk(st, 8'h02);
        pins(0, 0);
        power_on = 1'b1;
        wt(2);
        chk(st, 8'h0a);
        other_fault = 1'b1;
        wt(2);
        chk(st, 8'h02);
        other_fault = 1'b0;
        wt(2);
        chk(st, 8'h0a);
        clr();
        chk(st, 8'h08);
        chk(notes[7:0], 8'h07);
        // reset in mid-run restores the register
        rst_n = 1'b0;
        wt(1);
        chk(st, 8'h00);
        rst_n = 1'b1;
        wt(2);
        chk(st, 8'h08);
        host.rd(8'h47, d, h);
        chk(d, OC_RESP_CFG_RESET);
        give_verdict();
    end
endmodule

// >>> logic/overcurrent_fault_response.sv
// over-current fault response: config register, limit, shutdown, retry
// assumes comparator pins are asynchronous; commands, ticks and
// restart status come from logic on clk
//
// Overview of operation
// - A one-byte host read/write register at 0x47 holds the over-current response setup.
// - Every detected over-current fault sets the sticky status bit; the host is notified only when that bit was clear.
// - Response 00 keeps running and clamps current for as long as the fault lasts.
// - Response 01 clamps current but shuts down and retries once output voltage falls too low.
// - Response 10 clamps current for the delay time, then shuts down and retries if still limiting.
// - Response 11 shuts the output down at once and then follows the retry setting.
// - The retry field sets the number of restarts, 000 for none and 111 for unlimited.
// - With retry 000 the output stays off until the fault is cleared.
// - Retry 001 to 100 give one to four attempts, then the output latches off until cleared.
// - Successive restart attempts start one delay time apart.
// - The delay is two to the power of the delay field, in time-unit ticks.
// - Retry 101 and 110 give five and six attempts, 111 retries until off or another fault.
`timescale 1ns/1ps

module overcurrent_fault_response
    import overcurrent_fault_response_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire cmd_t       cmd,
    input  wire logic       oc_pin,
    input  wire logic       uv_pin,
    input  wire logic       unit_tick,
    input  wire logic       power_on,
    input  wire logic       other_fault,
    input  wire logic       restart_done,
    input  wire logic       fault_clear,
    output logic [7:0]      rdata_q,
    output logic            rvalid_q,
    output logic            rhit_q,
    output logic            output_enable_q,
    output logic            current_limit_q,
    output logic            fault_status_q,
    output logic            host_notify_q,
    output logic            latched_off_q
);

    // ========================================
    // pin synchronisers
    logic [1:0] pin_raw;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] pin_q;

    assign pin_raw = {uv_pin, oc_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                    pin_q[g]   <= 1'b0;
                end else begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    if (sync2_q[g] == sync3_q[g]) begin
                        pin_q[g] <= sync3_q[g];
                    end
                end
            end
        end
    endgenerate

    logic oc_f;
    logic uv_f;
    assign oc_f = pin_q[0];
    assign uv_f = pin_q[1];

    // ========================================
    // configuration register
    logic [7:0] cfg_q;
    oc_cfg_t    cfg;
    logic       cfg_hit;

    assign cfg_hit   = (cmd.code == OC_RESP_CFG_ADDR);
    assign cfg.resp  = resp_t'(cfg_q[RESP_MSB:RESP_LSB]);
    assign cfg.retry = cfg_q[RETRY_MSB:RETRY_LSB];
    assign cfg.delay = cfg_q[DELAY_MSB:DELAY_LSB];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q    <= OC_RESP_CFG_RESET;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            rhit_q   <= 1'b0;
        end else begin
            if (cmd.wr && cfg_hit) begin
                cfg_q <= cmd.wdata;
            end
            rvalid_q <= cmd.rd;
            rhit_q   <= cmd.rd && cfg_hit;
            rdata_q  <= (cmd.rd && cfg_hit) ? cfg_q : 8'h00;
        end
    end

    // ========================================
    // delay timer in time-unit ticks
    function automatic logic [7:0] delay_units(input logic [2:0] code);
        delay_units = 8'h01 << code;
    endfunction

    state_t     state_q;
    state_t     state_d;
    logic [7:0] dcnt_q;
    logic [7:0] dcnt_d;
    logic       delay_done;
    logic       timing;

    assign timing     = (state_q == ST_WAIT) ||
                        (state_q == ST_LIMIT && cfg.resp == RESP_DELAY);
    assign delay_done = timing && unit_tick &&
                        (dcnt_q == delay_units(cfg.delay) - 8'h01);

    always_comb begin
        dcnt_d = dcnt_q;
        if (state_d != state_q || !timing) begin
            dcnt_d = DELAY_RESET;
        end else if (unit_tick) begin
            dcnt_d = dcnt_q + 8'h01;
        end
    end

    // ========================================
    // response state machine
    logic [2:0] att_q;
    logic [2:0] att_d;
    logic       fault_evt;
    logic       can_retry;
    logic       halt;
    state_t     shut_to;

    assign halt      = !power_on || other_fault;
    assign fault_evt = oc_f && (state_q == ST_RUN || state_q == ST_RESTART);
    assign can_retry = (cfg.retry == RETRY_FOREVER) || (att_q < cfg.retry);
    assign shut_to   = (cfg.retry == RETRY_NONE) ? ST_LATCHED : ST_WAIT;

    always_comb begin
        state_d = state_q;
        att_d   = att_q;
        case (state_q)
            ST_OFF: begin
                if (!halt) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (oc_f) begin
                    if (cfg.resp == RESP_SHUTDOWN) begin
                        state_d = shut_to;
                    end else begin
                        state_d = ST_LIMIT;
                    end
                end
            end
            ST_LIMIT: begin
                if (!oc_f) begin
                    state_d = ST_RUN;
                end else if (cfg.resp == RESP_COND && uv_f) begin
                    state_d = shut_to;
                end else if (cfg.resp == RESP_DELAY && delay_done) begin
                    state_d = shut_to;
                end
            end
            ST_WAIT: begin
                if (delay_done) begin
                    if (can_retry) begin
                        state_d = ST_RESTART;
                        if (cfg.retry != RETRY_FOREVER) begin
                            att_d = att_q + 3'h1;
                        end
                    end else begin
                        state_d = ST_LATCHED;
                    end
                end
            end
            ST_RESTART: begin
                if (oc_f) begin
                    state_d = shut_to;
                end else if (restart_done) begin
                    state_d = ST_RUN;
                    att_d   = ATTEMPT_RESET;
                end
            end
            ST_LATCHED: begin
                if (fault_clear) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (halt && state_q != ST_LATCHED) begin
            state_d = ST_OFF;
            att_d   = ATTEMPT_RESET;
        end
        if (fault_clear) begin
            att_d = ATTEMPT_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q         <= ST_OFF;
            att_q           <= ATTEMPT_RESET;
            dcnt_q          <= DELAY_RESET;
            output_enable_q <= 1'b0;
            current_limit_q <= 1'b0;
            latched_off_q   <= 1'b0;
        end else begin
            state_q         <= state_d;
            att_q           <= att_d;
            dcnt_q          <= dcnt_d;
            output_enable_q <= (state_d == ST_RUN) || (state_d == ST_LIMIT) ||
                               (state_d == ST_RESTART);
            current_limit_q <= (state_d == ST_LIMIT);
            latched_off_q   <= (state_d == ST_LATCHED);
        end
    end

    // ========================================
    // status and host notification
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_status_q <= 1'b0;
            host_notify_q  <= 1'b0;
        end else begin
            // set wins over clear
            fault_status_q <= fault_evt || (fault_status_q && !fault_clear);
            host_notify_q  <= fault_evt && !fault_status_q;
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_running_fault;
        state_q == ST_RUN && oc_f && !halt;
    endsequence

    sequence s_limiting;
        state_q == ST_LIMIT && oc_f && !halt;
    endsequence

    a_cfg_write: assert property (
        cmd.wr && cfg_hit |=> cfg_q == $past(cmd.wdata))
        else $error("config write not stored");

    a_cfg_read: assert property (
        cmd.rd && cfg_hit |=> rvalid_q && rhit_q && rdata_q == $past(cfg_q))
        else $error("config read wrong");

    a_status_set: assert property (
        fault_evt |=> fault_status_q)
        else $error("fault status not set");

    a_ignore_clamp: assert property (
        s_running_fault ##0 cfg.resp == RESP_IGNORE
        |=> current_limit_q && output_enable_q)
        else $error("ignore response did not clamp");

    a_cond_cutoff: assert property (
        s_limiting ##0 cfg.resp == RESP_COND && uv_f |=> !output_enable_q)
        else $error("low voltage did not shut down");

    a_delay_cutoff: assert property (
        s_limiting ##0 cfg.resp == RESP_DELAY && delay_done
        |=> !output_enable_q && !current_limit_q)
        else $error("delay expiry did not shut down");

    a_immediate_off: assert property (
        s_running_fault ##0 cfg.resp == RESP_SHUTDOWN |=> !output_enable_q)
        else $error("shutdown response kept output on");

    a_latched_off: assert property (
        state_q == ST_LATCHED && !fault_clear |=> !output_enable_q[*2])
        else $error("latched output came back on");

    a_attempt_bound: assert property (
        att_q <= 3'h6)
        else $error("attempt counter overrun");

    a_forever_retry: assert property (
        state_q == ST_WAIT && delay_done && cfg.retry == RETRY_FOREVER && !halt
        |=> state_q == ST_RESTART && output_enable_q)
        else $error("unlimited retry stopped");

    a_count_clear: assert property (
        fault_clear |=> att_q == ATTEMPT_RESET)
        else $error("attempt counter not cleared");

endmodule

// >>> logic/overcurrent_fault_response_pkg.sv
// constants and types of the over-current fault response block
// assumes a command decoder that hands over one byte command at a time
package overcurrent_fault_response_pkg;

    // ========================================
    // register map
    localparam logic [7:0] OC_RESP_CFG_ADDR  = 8'h47;
    localparam logic [7:0] OC_RESP_CFG_RESET = 8'h00;

    // ========================================
    // field positions
    localparam int RESP_MSB  = 7;
    localparam int RESP_LSB  = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;

    // ========================================
    // encodings and counts
    typedef enum logic [1:0] {
        RESP_IGNORE   = 2'b00,
        RESP_COND     = 2'b01,
        RESP_DELAY    = 2'b10,
        RESP_SHUTDOWN = 2'b11
    } resp_t;

    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam logic [2:0] ATTEMPT_RESET = 3'h0;
    localparam logic [7:0] DELAY_RESET   = 8'h00;
    localparam int         SYNC_STAGES   = 3;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_RUN     = 3'b001,
        ST_LIMIT   = 3'b010,
        ST_WAIT    = 3'b011,
        ST_RESTART = 3'b100,
        ST_LATCHED = 3'b101
    } state_t;

    typedef struct packed {
        resp_t      resp;
        logic [2:0] retry;
        logic [2:0] delay;
    } oc_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] code;
        logic [7:0] wdata;
    } cmd_t;

endpackage
